// File: src/slb_built_in_link_test.v
// Purpose: at-speed link self test, deserializer side
// Assumes: pins from outside are synchronised here; link words arrive on link_clk edges
// Notes:   result flag pulses low for one link-clock half per failing word
//
// Function
// [RULE1] test covers serial forward link and the control channel at speed
// [RULE2] session starts only with link locked and enable both high
// [RULE3] session ends when enable falls; length equals enable width
// [RULE4] errors after enable falls do not change the result flag
// [RULE5] test only available in camera mode, not display mode
// [RULE6] gpio 1:0 select test clock: external, 50, 25, 12.5 MHz
// [RULE7] with selection 00 the outside supplies the serializer pixel clock
// [RULE8] device commands the serializer into test mode over back channel
// [RULE9] controller waits 10 ms then watches lock rise before reading results
// [RULE10] serializer sends internal pseudo-random sequence over the serial link
// [RULE11] flag high when clean; each failing payload drives it low half cycle
// [RULE12] consecutive failures toggle flag half high half low, countable
// [RULE13] both ends keep an accumulated error count register
// [RULE14] serializer gpio 0 flags control channel errors during the test
// [RULE15] controller stops the test by driving enable low
// [RULE16] outside applies normal data afterwards to resume normal operation
// [RULE17] final flag held until new session or power-down toggle
// [RULE18] after power-down toggle the flag defaults high
// [RULE19] camera mode: serializer role low, deserializer role high
// [RULE20] error counters clear when a new session starts
`timescale 1ns/10ps
`include "slb_defs.vh"
module slb_built_in_link_test (
  input  wire        sys_clk,
  input  wire        sys_rst,
  input  wire        self_test_enable,
  input  wire        link_locked,
  input  wire        power_down_n,
  input  wire        role_select,
  input  wire [1:0]  gpio_clk_sel,
  input  wire        link_clk,
  input  wire [15:0] link_word,
  input  wire        ctl_err,
  output reg         test_result_flag,
  output reg         test_active,
  output reg  [1:0]  back_cmd,
  output reg         back_cmd_valid,
  output reg  [1:0]  test_clk_sel,
  output reg  [15:0] fwd_err_count,
  output reg  [15:0] ctl_err_count,
  output reg         word_overrun
);
  localparam ST_IDLE = 2'h0;
  localparam ST_RUN  = 2'h1;
  localparam ST_DONE = 2'h2;

  // two-stage synchronisers for all pins
  reg [1:0]  en_s_q;
  reg [1:0]  lock_s_q;
  reg [1:0]  pdn_s_q;
  reg [1:0]  role_s_q;
  reg [1:0]  lclk_s_q;
  reg [1:0]  cerr_s_q;
  reg [1:0]  sel0_s_q;
  reg [1:0]  sel1_s_q;
  reg [15:0] wd_s1_q;
  reg [15:0] wd_s2_q;
  reg        lclk_prev_q;
  reg        cerr_prev_q;
  reg        pdn_prev_q;

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      en_s_q   <= 2'h0;
      lock_s_q <= 2'h0;
      pdn_s_q  <= 2'h3;
      role_s_q <= 2'h0;
      lclk_s_q <= 2'h0;
      cerr_s_q <= 2'h0;
      sel0_s_q <= 2'h0;
      sel1_s_q <= 2'h0;
      wd_s1_q  <= 16'h0000;
      wd_s2_q  <= 16'h0000;
    end else begin
      en_s_q   <= {en_s_q[0], self_test_enable};
      lock_s_q <= {lock_s_q[0], link_locked};
      pdn_s_q  <= {pdn_s_q[0], power_down_n};
      role_s_q <= {role_s_q[0], role_select};
      lclk_s_q <= {lclk_s_q[0], link_clk};
      cerr_s_q <= {cerr_s_q[0], ctl_err};
      sel0_s_q <= {sel0_s_q[0], gpio_clk_sel[0]};
      sel1_s_q <= {sel1_s_q[0], gpio_clk_sel[1]};
      wd_s1_q  <= link_word;
      wd_s2_q  <= wd_s1_q;
    end
  end

  wire en_s     = en_s_q[1];
  wire lock_s   = lock_s_q[1];
  wire pdn_s    = pdn_s_q[1];
  wire camera_s = role_s_q[1];
  wire lclk_s   = lclk_s_q[1];
  wire lclk_rise = lclk_s & ~lclk_prev_q;
  wire lclk_fall = ~lclk_s & lclk_prev_q;
  wire cerr_rise = cerr_s_q[1] & ~cerr_prev_q;
  wire pdn_release = pdn_s & ~pdn_prev_q;

  reg  [1:0] st_q;
  reg  [1:0] st_d;
  wire       start_ok = en_s & lock_s & camera_s;          // [RULE2] [RULE5] [RULE19]
  wire       in_run   = (st_q == ST_RUN);

  always @* begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (start_ok) begin
          st_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!en_s || !camera_s) begin
          st_d = ST_DONE;                                   // [RULE3]
        end
      end
      ST_DONE: begin
        if (!en_s) begin
          st_d = ST_IDLE;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  // link words go through the buffer; checker drains on link falling edge
  wire [15:0] fifo_out;
  wire        fifo_valid;
  wire        fifo_in_ready;
  wire        chk_take = fifo_valid & lclk_fall & in_run;
  wire        push_word = lclk_rise & in_run;
  wire [15:0] expect_word;

  slb_fifo #(
    .W (`SLB_WORD_W),
    .D (`SLB_FIFO_DEPTH),
    .A (2)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst | ~in_run),
    .in_data   (wd_s2_q),
    .in_valid  (push_word),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_valid),
    .out_ready (chk_take)
  );

  // local copy of the pattern the serializer sends
  slb_prbs u_prbs (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .reseed  (st_q == ST_IDLE),
    .advance (chk_take),                                    // [RULE10]
    .word    (expect_word)
  );

  wire word_bad = chk_take & (fifo_out != expect_word);     // [RULE1]

  reg  fail_hold_q;

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      st_q             <= ST_IDLE;
      lclk_prev_q      <= 1'b0;
      cerr_prev_q      <= 1'b0;
      pdn_prev_q       <= 1'b1;
      test_result_flag <= `SLB_PASS_RESET;
      test_active      <= 1'b0;
      back_cmd         <= `SLB_CMD_IDLE;
      back_cmd_valid   <= 1'b0;
      test_clk_sel     <= `SLB_CLKSEL_EXT;
      fwd_err_count    <= 16'h0000;
      ctl_err_count    <= 16'h0000;
      word_overrun     <= 1'b0;
      fail_hold_q      <= 1'b0;
    end else begin
      st_q        <= st_d;
      lclk_prev_q <= lclk_s;
      cerr_prev_q <= cerr_s_q[1];
      pdn_prev_q  <= pdn_s;
      test_active <= (st_d == ST_RUN);
      back_cmd_valid <= 1'b0;
      if (st_q == ST_IDLE && st_d == ST_RUN) begin
        test_clk_sel   <= {sel1_s_q[1], sel0_s_q[1]};       // [RULE6]
        back_cmd       <= `SLB_CMD_START;                   // [RULE8]
        back_cmd_valid <= 1'b1;
        fwd_err_count  <= 16'h0000;                         // [RULE20]
        ctl_err_count  <= 16'h0000;                         // [RULE20]
        word_overrun   <= 1'b0;
        test_result_flag <= 1'b1;
        fail_hold_q    <= 1'b0;
      end else if (st_q == ST_RUN && st_d != ST_RUN) begin
        back_cmd       <= `SLB_CMD_STOP;
        back_cmd_valid <= 1'b1;
        test_result_flag <= ~fail_hold_q;                   // [RULE17]
      end else if (in_run) begin
        if (word_bad) begin
          fwd_err_count    <= fwd_err_count + 16'h0001;     // [RULE13]
          test_result_flag <= 1'b0;                         // [RULE11] [RULE12]
          fail_hold_q      <= 1'b1;
        end else if (lclk_rise) begin
          test_result_flag <= ~fail_hold_q | 1'b1;          // [RULE12]
        end
        if (cerr_rise) begin
          ctl_err_count <= ctl_err_count + 16'h0001;        // [RULE1] [RULE14]
        end
        if (push_word && !fifo_in_ready) begin
          word_overrun <= 1'b1;
        end
      end else if (pdn_release) begin
        test_result_flag <= `SLB_PASS_RESET;                // [RULE18]
      end
      // [RULE4] outside the run state nothing updates the flag from errors
    end
  end
endmodule

// File: src/slb_defs.vh
// Purpose: constants for the at-speed link self test block
// Assumes: 40 MHz system clock
// Notes:   timing counts derived from the times printed beside them
`ifndef SLB_DEFS_VH
`define SLB_DEFS_VH
`define SLB_CLK_MHZ        40
`define SLB_CLKSEL_EXT     2'h0
`define SLB_CLKSEL_50M     2'h1
`define SLB_CLKSEL_25M     2'h2
`define SLB_CLKSEL_12M5    2'h3
`define SLB_PASS_RESET     1'b1
`define SLB_ERRCNT_W       16
`define SLB_WORD_W         16
`define SLB_FIFO_DEPTH     4
`define SLB_PRBS_SEED      16'hace1
`define SLB_CMD_IDLE       2'h0
`define SLB_CMD_START      2'h1
`define SLB_CMD_STOP       2'h2
`define SLB_LOCK_WAIT_MS   10
`define SLB_LOCK_WAIT_CYC  (`SLB_LOCK_WAIT_MS * 1000 * `SLB_CLK_MHZ)
`endif

// File: src/slb_fifo.v
// Purpose: small word buffer with valid/ready on both sides
// Assumes: single clock, synchronous active-high reset
// Notes:   depth must be a power of two
`timescale 1ns/10ps
module slb_fifo #(
  parameter W = 16,
  parameter D = 4,
  parameter A = 2
) (
  input  wire         sys_clk,
  input  wire         sys_rst,
  input  wire [W-1:0] in_data,
  input  wire         in_valid,
  output wire         in_ready,
  output wire [W-1:0] out_data,
  output wire         out_valid,
  input  wire         out_ready
);
  reg [W-1:0] mem_q [0:D-1];
  reg [A:0]   wr_q;
  reg [A:0]   rd_q;
  wire        full  = (wr_q[A] != rd_q[A]) && (wr_q[A-1:0] == rd_q[A-1:0]);
  wire        empty = (wr_q == rd_q);
  wire        push  = in_valid & ~full;
  wire        pop   = out_ready & ~empty;
  assign in_ready  = ~full;
  assign out_valid = ~empty;
  assign out_data  = mem_q[rd_q[A-1:0]];
  always @(posedge sys_clk) begin
    if (push) begin
      mem_q[wr_q[A-1:0]] <= in_data;
    end
  end
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      wr_q <= {(A+1){1'b0}};
      rd_q <= {(A+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule

// File: src/slb_prbs.v
// Purpose: 16-bit word generator for the test pattern, x^16+x^14+x^13+x^11+1
// Assumes: advance is a one-cycle strobe
// Notes:   used for checking; the serializer model repeats the same steps so both sides agree
`timescale 1ns/10ps
module slb_prbs (
  input  wire        sys_clk,
  input  wire        sys_rst,
  input  wire        reseed,
  input  wire        advance,
  output wire [15:0] word
);
  reg [15:0] lfsr_q;
  reg [15:0] lfsr_d;
  integer    i;
  assign word = lfsr_q;
  always @* begin
    lfsr_d = lfsr_q;
    for (i = 0; i < 16; i = i + 1) begin
      lfsr_d = {lfsr_d[14:0], lfsr_d[15] ^ lfsr_d[13] ^ lfsr_d[12] ^ lfsr_d[10]};
    end
  end
  always @(posedge sys_clk) begin
    if (sys_rst || reseed) begin
      lfsr_q <= `SLB_PRBS_SEED;
    end else if (advance) begin
      lfsr_q <= lfsr_d;
    end
  end
endmodule

// File: verification/slb_built_in_link_test_checker.sv
// Purpose: port-level timing checks for the link self test block
// Assumes: pins stay steady around a session start
// Notes:   link half cycle is four system cycles
`timescale 1ns/10ps
`include "slb_defs.vh"
module slb_built_in_link_test_checker (
  input wire        sys_clk,
  input wire        sys_rst,
  input wire        self_test_enable,
  input wire        link_locked,
  input wire        power_down_n,
  input wire        role_select,
  input wire [1:0]  gpio_clk_sel,
  input wire        test_result_flag,
  input wire        test_active,
  input wire [1:0]  back_cmd,
  input wire        back_cmd_valid,
  input wire [1:0]  test_clk_sel,
  input wire [15:0] fwd_err_count,
  input wire [15:0] ctl_err_count
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  reg [4:0] pd_h;
  always @(posedge sys_clk) pd_h <= {pd_h[3:0], power_down_n};
  property p_start_ok;
    $rose(test_active) |-> link_locked && self_test_enable && role_select;
  endproperty
  a_start_ok: assert property (p_start_ok) else $error("start without lock");
  property p_start_cmd;
    $rose(test_active) |-> back_cmd_valid && back_cmd == `SLB_CMD_START;
  endproperty
  a_start_cmd: assert property (p_start_cmd) else $error("no start command");
  property p_cmd_pulse;
    back_cmd_valid |=> !back_cmd_valid;
  endproperty
  a_cmd_pulse: assert property (p_cmd_pulse) else $error("command pulse too long");
  property p_end_drop;
    $fell(self_test_enable) |-> ##[1:6] !test_active;
  endproperty
  a_end_drop: assert property (p_end_drop) else $error("session outlived enable");
  property p_flag_hold;
    !test_active && $past(!test_active, 2) && (&pd_h) |-> $stable(test_result_flag);
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("idle flag moved");
  property p_pd_high;
    $rose(power_down_n) && !test_active |-> ##[2:6] test_result_flag;
  endproperty
  a_pd_high: assert property (p_pd_high) else $error("flag not high after wake");
  property p_fail_half;
    $fell(test_result_flag) && self_test_enable |=> !test_result_flag ##[1:6] test_result_flag;
  endproperty
  a_fail_half: assert property (p_fail_half) else $error("fail pulse width wrong");
  property p_cnt_clear;
    $rose(test_active) |=> fwd_err_count == 16'h0 && ctl_err_count == 16'h0;
  endproperty
  a_cnt_clear: assert property (p_cnt_clear) else $error("counts not cleared");
  property p_sel_cap;
    $rose(test_active) |=> test_clk_sel == gpio_clk_sel;
  endproperty
  a_sel_cap: assert property (p_sel_cap) else $error("clock select not captured");
  c_start: cover property ($rose(test_active));
  c_fail: cover property ($fell(test_result_flag) && test_active);
  c_pd: cover property ($rose(power_down_n));
endmodule

// File: verification/slb_ser_model.sv
// Purpose: far-end serializer: follows back channel, sends pattern words
// Assumes: linger keeps sending after stop; bad flips bit 0 of each word
// Notes:   link clock stands low while not sending
`timescale 1ns/10ps
`include "slb_defs.vh"
module slb_ser_model (
  input  wire        sys_clk,
  input  wire        sys_rst,
  input  wire [1:0]  back_cmd,
  input  wire        back_cmd_valid,
  input  wire        bad,
  input  wire        linger,
  output reg         link_clk,
  output wire [15:0] link_word
);
  reg         hold_q;
  reg         run_q;
  reg  [1:0]  lc_q;
  reg  [15:0] pat;
  // sixteen steps of x^16+x^14+x^13+x^11+1 per word
  function [15:0] nxt(input [15:0] v);
    integer    j;
    reg [15:0] t;
    begin
      t = v;
      for (j = 0; j < 16; j = j + 1) t = {t[14:0], t[15] ^ t[13] ^ t[12] ^ t[10]};
      nxt = t;
    end
  endfunction
  always @(posedge sys_clk) begin
    if (sys_rst) hold_q <= 1'b0;
    else if (back_cmd_valid) hold_q <= back_cmd == `SLB_CMD_START;
    run_q <= ~sys_rst & (hold_q | linger & run_q);
    lc_q <= {lc_q[0], link_clk};
  end
  initial link_clk = 1'b0;
  always #100 link_clk = run_q & ~link_clk;
  always @(posedge sys_clk) begin
    if (sys_rst || back_cmd_valid) pat <= `SLB_PRBS_SEED;
    else if (lc_q[1] & ~lc_q[0]) pat <= nxt(pat);
  end
  // normal data again once the session is over
  assign link_word = run_q ? pat ^ {15'h0, bad} : ~pat;
endmodule

// File: verification/tb.sv
// Purpose: self-checking bench for the link self test block
// Assumes: serializer model on the link side
// Notes:   outcome compared four cycles after each stop command
`timescale 1ns/10ps
`include "slb_defs.vh"
module tb;
  logic sys_clk, sys_rst, self_test_enable, link_locked, power_down_n, role_select;
  logic [1:0] gpio_clk_sel, back_cmd, test_clk_sel;
  logic ctl_err, bad, linger, link_clk, test_result_flag, test_active, back_cmd_valid;
  logic word_overrun;
  logic [15:0] link_word, fwd_err_count, ctl_err_count;
  logic [1:0]  cq[$];
  logic [34:0] oq[$];
  logic [2:0]  st = 3'd0;
  logic [31:0] seed;
  integer failures, checks, n, cyc = 0;
  slb_built_in_link_test u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .self_test_enable(self_test_enable),
    .link_locked(link_locked), .power_down_n(power_down_n), .role_select(role_select),
    .gpio_clk_sel(gpio_clk_sel), .link_clk(link_clk), .link_word(link_word), .ctl_err(ctl_err),
    .test_result_flag(test_result_flag), .test_active(test_active), .back_cmd(back_cmd),
    .back_cmd_valid(back_cmd_valid), .test_clk_sel(test_clk_sel),
    .fwd_err_count(fwd_err_count), .ctl_err_count(ctl_err_count), .word_overrun(word_overrun));
  slb_ser_model u_ser (.sys_clk(sys_clk), .sys_rst(sys_rst), .back_cmd(back_cmd),
    .back_cmd_valid(back_cmd_valid), .bad(bad), .linger(linger), .link_clk(link_clk),
    .link_word(link_word));
  always #12.5 sys_clk = ~sys_clk;
  function [31:0] xs(input [31:0] v);
    reg [31:0] t;
    begin
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task chk(input [35:0] got, input [35:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task summarize;
    begin
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task session(input [1:0] s, input integer k, input integer c);
    integer i;
    begin
      gpio_clk_sel <= s;
      cq.push_back(`SLB_CMD_START);
      cq.push_back(`SLB_CMD_STOP);
      oq.push_back({s, k == 0, k[15:0], c[15:0]});
      repeat (3) @(posedge sys_clk);
      self_test_enable <= 1'b1;
      repeat (40) @(posedge sys_clk);
      @(negedge link_clk);
      @(posedge sys_clk) bad <= k != 0;
      repeat (k) @(negedge link_clk);
      @(posedge sys_clk) bad <= 1'b0;
      for (i = 0; i < c; i = i + 1) begin
        @(posedge sys_clk) ctl_err <= 1'b1;
        repeat (3) @(posedge sys_clk);
        ctl_err <= 1'b0;
        repeat (3) @(posedge sys_clk);
      end
      repeat (40) @(posedge sys_clk);
      linger <= 1'b1;
      @(negedge link_clk);
      @(posedge sys_clk);
      self_test_enable <= 1'b0;
      bad <= 1'b1; // late errors must not count
      repeat (60) @(posedge sys_clk);
      bad <= 1'b0;
      linger <= 1'b0;
      repeat (20) @(posedge sys_clk);
      $display("session with select %0d done", s);
    end
  endtask
  always @(posedge sys_clk) begin
    if (back_cmd_valid === 1'b1) begin
      if (cq.size() == 0) chk(36'h1, 36'h0);
      else chk(36'(back_cmd), 36'(cq.pop_front()));
      st <= (back_cmd == `SLB_CMD_STOP) ? 3'd1 : 3'd0;
    end else if (st != 3'd0) st <= st + 3'd1;
    if (st == 3'd4)
      chk(36'({test_clk_sel, test_result_flag, fwd_err_count, ctl_err_count}), 36'(oq.pop_front()));
  end
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      failures = failures + 1;
      summarize;
    end
  end
  initial begin
    sys_clk = 0; sys_rst = 1; self_test_enable = 0; link_locked = 0; power_down_n = 1;
    role_select = 1; gpio_clk_sel = 0; ctl_err = 0; bad = 0; linger = 0;
    failures = 0; checks = 0; seed = 32'h89e0;
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    self_test_enable <= 1'b1;
    repeat (20) @(posedge sys_clk);
    link_locked <= 1'b1;
    role_select <= 1'b0;
    repeat (20) @(posedge sys_clk);
    self_test_enable <= 1'b0;
    role_select <= 1'b1;
    repeat (10) @(posedge sys_clk);
    $display("refused starts done");
    for (n = 0; n < 4; n = n + 1) begin
      seed = xs(seed);
      session(n[1:0], n == 0 ? 0 : seed[1:0] + 1, seed[3:2]);
    end
    chk(36'(test_result_flag), 36'h0);
    power_down_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    power_down_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk(36'(test_result_flag), 36'h1);
    chk(36'(word_overrun), 36'h0);
    $display("power-down test done");
    summarize;
  end
endmodule
bind slb_built_in_link_test slb_built_in_link_test_checker u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .self_test_enable(self_test_enable), .link_locked(link_locked), .power_down_n(power_down_n),
  .role_select(role_select), .gpio_clk_sel(gpio_clk_sel), .test_result_flag(test_result_flag),
  .test_active(test_active), .back_cmd(back_cmd), .back_cmd_valid(back_cmd_valid),
  .test_clk_sel(test_clk_sel), .fwd_err_count(fwd_err_count), .ctl_err_count(ctl_err_count));
